// ### logic/afe_spi_port.v
// serial command port of the sensor front end, slave side
`timescale 1ns/1ps
`default_nettype none
`include "afe_spi_map.vh"
module afe_spi_port #(
  parameter [15:0] LAT512_CYC = `AFE_LAT512_US * `AFE_CLK_MHZ,
  parameter [15:0] LAT256_CYC = `AFE_LAT256_US * `AFE_CLK_MHZ,
  parameter [15:0] LAT128_CYC = `AFE_LAT128_US * `AFE_CLK_MHZ,
  parameter [15:0] LAT64_CYC = `AFE_LAT64_US * `AFE_CLK_MHZ,
  parameter [15:0] CORR_CYC = `AFE_CORR_US * `AFE_CLK_MHZ
) (
  input wire CLK_SYS,
  input wire SRST,
  input wire CE,
  input wire SCK,
  input wire SDI,
  output reg SDO,
  input wire [1:0] OVERSAMPLING_RATIO,
  input wire [18:0] SAMPLE_RAW,
  input wire [18:0] OFFSET_VALUE
);

  // --------------------------------------------------------------------------
  // pin synchronisation and edge detection
  // --------------------------------------------------------------------------
  // no select line exists, framing comes from counting bits only
  wire [1:0] pin_s;
  wire sck_s;
  wire sdi_s;
  reg sck_d_r;
  wire sck_rise;
  wire sck_fall;
  reg soft_rst_r;
  wire rst_all;

  assign rst_all = SRST | soft_rst_r;

  afe_sync #(
    .W(2)
  ) u_sync (
    .clk(CLK_SYS),
    .ce(CE),
    .rst(SRST),
    .d({SCK, SDI}),
    .q(pin_s)
  );

  assign sck_s = pin_s[1];
  assign sdi_s = pin_s[0];

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      sck_d_r <= 1'b0;
    end else if (CE) begin
      sck_d_r <= sck_s;
    end
  end

  // both pins pass the same two stages, so data stays aligned to the clock
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  // --------------------------------------------------------------------------
  // in-band reset detection
  // --------------------------------------------------------------------------
  reg zero_seen_r;
  reg [4:0] ones_cnt_r;
  wire ones_last;

  assign ones_last = (ones_cnt_r == (`AFE_RST_ONES - 5'h01));

  always @(posedge CLK_SYS) begin
    if (rst_all) begin
      zero_seen_r <= 1'b0;
      ones_cnt_r <= 5'h00;
      soft_rst_r <= 1'b0;
    end else if (CE) begin
      soft_rst_r <= 1'b0;
      if (sck_fall) begin
        if (!sdi_s) begin
          zero_seen_r <= 1'b1;
          ones_cnt_r <= 5'h00;
        end else if (zero_seen_r) begin
          if (ones_last) begin
            soft_rst_r <= 1'b1;
          end
          ones_cnt_r <= ones_cnt_r + 5'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // transaction framing
  // --------------------------------------------------------------------------
  reg phase_data_r;
  reg active_r;
  reg [4:0] bit_cnt_r;
  reg [4:0] len_r;
  reg [15:0] rx_r;
  reg [15:0] tx_r;
  reg [7:0] cmd_r;
  reg tx_bit_r;
  wire [7:0] cmd_nxt;
  wire [15:0] rx_nxt;
  wire cmd_done;
  wire data_done;
  wire [3:0] cmd_addr;
  wire cmd_read;
  wire cmd_two;
  wire [3:0] cur_addr;
  wire cur_read;
  wire cur_two;

  assign rx_nxt = {rx_r[14:0], sdi_s};
  assign cmd_nxt = rx_nxt[7:0];
  assign cmd_done = sck_fall && !phase_data_r && (bit_cnt_r == (`AFE_CMD_BITS - 5'h01));
  assign data_done = sck_fall && phase_data_r && (bit_cnt_r == (len_r - 5'h01));

  assign cmd_addr = cmd_nxt[`AFE_CMD_ADDR_HI:`AFE_CMD_ADDR_LO];
  assign cmd_read = cmd_nxt[`AFE_CMD_RW];
  assign cmd_two = cmd_nxt[`AFE_CMD_BC];
  assign cur_addr = cmd_r[`AFE_CMD_ADDR_HI:`AFE_CMD_ADDR_LO];
  assign cur_read = cmd_r[`AFE_CMD_RW];
  assign cur_two = cmd_r[`AFE_CMD_BC];

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [3:0] mode_r;
  reg swap_r;
  reg start_single_r;
  reg [7:0] sample_hi_r;
  reg [7:0] sample_lo_r;
  reg got_first_r;
  reg read_ack_r;
  wire busy;
  wire clip;
  wire conv_done;
  wire [15:0] result;
  wire [7:0] ctrl_val;
  wire [7:0] status_val;
  wire [3:0] addr_next;
  wire [7:0] wr_first;
  wire [7:0] wr_second;

  assign ctrl_val = {1'b0, swap_r, busy, clip, mode_r};
  // status byte during the command phase
  assign status_val = {6'h00, busy, clip};
  assign addr_next = cmd_addr + 4'h1;

  function [7:0] rd_byte;
    input [3:0] a;
    begin
      if (a == `AFE_ADDR_CTRL) begin
        rd_byte = ctrl_val;
      end else if (a == `AFE_ADDR_SAMPLE0) begin
        rd_byte = sample_hi_r;
      end else if (a == `AFE_ADDR_SAMPLE1) begin
        rd_byte = sample_lo_r;
      end else begin
        rd_byte = `AFE_BYTE_ZERO;
      end
    end
  endfunction

  // first data byte goes to the named address; the second byte, wr_second, is not written anywhere
  assign wr_first = cur_two ? rx_nxt[15:8] : rx_nxt[7:0];
  assign wr_second = rx_nxt[7:0];

  // --------------------------------------------------------------------------
  // shift engine
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (rst_all) begin
      phase_data_r <= 1'b0;
      active_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      len_r <= `AFE_LEN_ONE;
      rx_r <= 16'h0000;
      tx_r <= 16'h0000;
      cmd_r <= `AFE_BYTE_ZERO;
      tx_bit_r <= 1'b0;
    end else if (CE) begin
      if (sck_rise) begin
        // output moves on the rising edge only
        active_r <= 1'b1;
        tx_bit_r <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
      end else if (!active_r && !phase_data_r) begin
        // keep the status current until the first clock of a command
        tx_r <= {status_val, `AFE_BYTE_ZERO};
      end
      if (sck_fall) begin
        rx_r <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (cmd_done) begin
        cmd_r <= cmd_nxt;
        phase_data_r <= 1'b1;
        bit_cnt_r <= 5'h00;
        len_r <= cmd_two ? `AFE_LEN_TWO : `AFE_LEN_ONE;
        if (cmd_read) begin
          tx_r <= {rd_byte(cmd_addr), cmd_two ? rd_byte(addr_next) : `AFE_BYTE_ZERO};
        end else begin
          tx_r <= 16'h0000;
        end
      end
      if (data_done) begin
        // back to waiting for a command byte
        phase_data_r <= 1'b0;
        active_r <= 1'b0;
        bit_cnt_r <= 5'h00;
      end
    end
  end

  // idle line carries ready/busy, a transfer carries the shifted bit
  always @(posedge CLK_SYS) begin
    if (rst_all) begin
      SDO <= 1'b0;
    end else if (CE) begin
      SDO <= active_r ? tx_bit_r : busy;
    end
  end

  // --------------------------------------------------------------------------
  // register writes and result capture
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (rst_all) begin
      mode_r <= `AFE_MODE_RST;
      swap_r <= 1'b0;
      start_single_r <= 1'b0;
      sample_hi_r <= `AFE_BYTE_ZERO;
      sample_lo_r <= `AFE_BYTE_ZERO;
    end else if (CE) begin
      start_single_r <= 1'b0;
      if (data_done && !cur_read && (cur_addr == `AFE_ADDR_CTRL)) begin
        mode_r <= wr_first[`AFE_CTRL_MODE_HI:`AFE_CTRL_MODE_LO];
        swap_r <= wr_first[`AFE_CTRL_SWAP];
        if (wr_first[`AFE_CTRL_MODE_HI:`AFE_CTRL_MODE_LO] == `AFE_MODE_SINGLE) begin
          start_single_r <= 1'b1;
        end
      end
      if (conv_done) begin
        sample_hi_r <= result[15:8];
        sample_lo_r <= result[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // result read tracking
  // --------------------------------------------------------------------------
  // a two-byte read of 0x1 or 0x2, or single reads of 0x1 then 0x2, releases the result
  wire rd_first_now;
  wire rd_second_now;

  assign rd_first_now = data_done && cur_read && (cur_addr == `AFE_ADDR_SAMPLE0);
  assign rd_second_now = data_done && cur_read &&
                         ((cur_addr == `AFE_ADDR_SAMPLE1) ||
                          ((cur_addr == `AFE_ADDR_SAMPLE0) && cur_two));

  always @(posedge CLK_SYS) begin
    if (rst_all) begin
      got_first_r <= 1'b0;
      read_ack_r <= 1'b0;
    end else if (CE) begin
      read_ack_r <= 1'b0;
      if (conv_done) begin
        // a fresh result needs a fresh pair of reads
        got_first_r <= 1'b0;
      end else if (rd_second_now && (got_first_r || cur_two)) begin
        read_ack_r <= 1'b1;
        got_first_r <= 1'b0;
      end else if (rd_first_now) begin
        got_first_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------------------
  afe_conv_seq #(
    .LAT512_CYC(LAT512_CYC),
    .LAT256_CYC(LAT256_CYC),
    .LAT128_CYC(LAT128_CYC),
    .LAT64_CYC(LAT64_CYC),
    .CORR_CYC(CORR_CYC)
  ) u_conv (
    .clk(CLK_SYS),
    .ce(CE),
    .rst(rst_all),
    .start_single(start_single_r),
    .cont_en(mode_r == `AFE_MODE_CONT),
    .read_ack(read_ack_r),
    .oversampling_ratio(OVERSAMPLING_RATIO),
    .swap(swap_r),
    .sample_raw(SAMPLE_RAW),
    .offset(OFFSET_VALUE),
    .busy_r(busy),
    .result_r(result),
    .clip_r(clip),
    .done_r(conv_done)
  );

endmodule
`default_nettype wire

// ### inc/afe_spi_map.vh
// constants and field layout of the sensor front end serial command port
//
// Functional notes
// - three wires only: clock, data in, shared data-out/ready; select tied inside.
// - device samples input on falling clock edge, changes output on rising edge.
// - every byte, command or data, is shifted most significant bit first.
// - one command byte then 8 or 16 data bits, then wait for next command.
// - outside a transaction the output pin shows ready/busy: high busy, low done.
// - command bits 7..4 give the register address.
// - command bit 3 low means write, high means read.
// - command bit 2 high means two bytes: address then address plus one.
// - status byte shifted out during command: zeros, ready/busy in bit1, clip in bit0.
// - a zero followed by 23 ones on the input resets the whole device.
// - writing mode 0x2 to the control register at 0x0 starts one conversion.
// - writing mode 0x3 starts back-to-back conversions until mode changes.
// - result sits in two data registers from 0x1, read by two-byte read.
// - in continuous mode ready/busy falls when a corrected result is ready.
// - in continuous mode ready/busy rises once both result registers are read.
// - unread result: ready/busy rises at next raw conversion end, old result dropped.
// - after a drop ready/busy falls again after correction time; repeats each cycle.
// - single latency 1255, 640, 333, 180 us for ratios 512, 256, 128, 64.
// - input-swap mode skips the stored offset during offset correction.
// - corrected result beyond signed 16 bits sets clip flag and saturates; else clears.
`ifndef AFE_SPI_MAP_VH
`define AFE_SPI_MAP_VH

// ----------------------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------------------
`define AFE_CMD_ADDR_HI 7
`define AFE_CMD_ADDR_LO 4
`define AFE_CMD_RW 3
`define AFE_CMD_BC 2

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define AFE_ADDR_CTRL 4'h0
`define AFE_ADDR_SAMPLE0 4'h1
`define AFE_ADDR_SAMPLE1 4'h2
`define AFE_CTRL_SWAP 6
`define AFE_CTRL_RDY 5
`define AFE_CTRL_CLIP 4
`define AFE_CTRL_MODE_HI 3
`define AFE_CTRL_MODE_LO 0
`define AFE_MODE_RST 4'h0
`define AFE_MODE_SINGLE 4'h2
`define AFE_MODE_CONT 4'h3
`define AFE_BYTE_ZERO 8'h00

// ----------------------------------------------------------------------------
// framing
// ----------------------------------------------------------------------------
`define AFE_CMD_BITS 5'h08
`define AFE_LEN_ONE 5'h08
`define AFE_LEN_TWO 5'h10
`define AFE_RST_ONES 5'h17
`define AFE_OSR_512 2'h0
`define AFE_OSR_256 2'h1
`define AFE_OSR_128 2'h2
`define AFE_OSR_64 2'h3

// ----------------------------------------------------------------------------
// timing, in microseconds and clock rate in MHz
// ----------------------------------------------------------------------------
`define AFE_CLK_MHZ 16'h0019
`define AFE_LAT512_US 16'h04e7
`define AFE_LAT256_US 16'h0280
`define AFE_LAT128_US 16'h014d
`define AFE_LAT64_US 16'h00b4
`define AFE_CORR_US 16'h0014

// ----------------------------------------------------------------------------
// result range
// ----------------------------------------------------------------------------
`define AFE_RES_MAX 16'h7fff
`define AFE_RES_MIN 16'h8000
`define AFE_SCALE_SHIFT 3

`endif

// ### logic/afe_sync.v
// two-stage synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module afe_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire ce,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clk) begin
        if (rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else if (ce) begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ### logic/afe_conv_seq.v
// conversion sequencer: raw conversion, correction, ready/busy and clip
`timescale 1ns/1ps
`default_nettype none
`include "afe_spi_map.vh"
module afe_conv_seq #(
  parameter [15:0] LAT512_CYC = 16'h7a8f,
  parameter [15:0] LAT256_CYC = 16'h3e80,
  parameter [15:0] LAT128_CYC = 16'h2085,
  parameter [15:0] LAT64_CYC = 16'h1194,
  parameter [15:0] CORR_CYC = 16'h01f4
) (
  input wire clk,
  input wire ce,
  input wire rst,
  input wire start_single,
  input wire cont_en,
  input wire read_ack,
  input wire [1:0] oversampling_ratio,
  input wire swap,
  input wire [18:0] sample_raw,
  input wire [18:0] offset,
  output reg busy_r,
  output reg [15:0] result_r,
  output reg clip_r,
  output reg done_r
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CONV = 2'b01;
  localparam [1:0] ST_CORR = 2'b10;

  reg [1:0] state_r;
  reg [15:0] cnt_r;
  reg pending_r;
  reg signed [19:0] diff_r;
  reg [15:0] lat_sel;
  wire [15:0] conv_len;
  wire signed [19:0] off_used;
  wire signed [19:0] diff_nxt;
  wire signed [16:0] scaled;

  always @* begin
    case (oversampling_ratio)
      `AFE_OSR_512: lat_sel = LAT512_CYC;
      `AFE_OSR_256: lat_sel = LAT256_CYC;
      `AFE_OSR_128: lat_sel = LAT128_CYC;
      default: lat_sel = LAT64_CYC;
    endcase
  end
  // latency covers raw conversion plus correction
  assign conv_len = lat_sel - CORR_CYC;

  // swapping inputs already cancels offset
  assign off_used = swap ? 20'sh00000 : {offset[18], offset};
  assign diff_nxt = {sample_raw[18], sample_raw} - off_used;
  assign scaled = diff_r[19:`AFE_SCALE_SHIFT];

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      pending_r <= 1'b0;
      busy_r <= 1'b0;
      result_r <= 16'h0000;
      clip_r <= 1'b0;
      done_r <= 1'b0;
      diff_r <= 20'sh00000;
    end else if (ce) begin
      done_r <= 1'b0;
      // reading both bytes re-arms the busy level
      if (read_ack && cont_en && pending_r) begin
        busy_r <= 1'b1;
        pending_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (start_single || cont_en) begin
            state_r <= ST_CONV;
            cnt_r <= conv_len - 16'h0001;
            busy_r <= 1'b1;
          end
        end
        ST_CONV: begin
          if (cnt_r == 16'h0000) begin
            diff_r <= diff_nxt;
            state_r <= ST_CORR;
            cnt_r <= CORR_CYC - 16'h0001;
            if (pending_r) begin
              busy_r <= 1'b1;
              pending_r <= 1'b0;
            end
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        ST_CORR: begin
          if (cnt_r == 16'h0000) begin
            // saturate to the signed 16-bit limits
            if (scaled > $signed({1'b0, `AFE_RES_MAX})) begin
              result_r <= `AFE_RES_MAX;
              clip_r <= 1'b1;
            end else if (scaled < $signed({1'b1, `AFE_RES_MIN})) begin
              result_r <= `AFE_RES_MIN;
              clip_r <= 1'b1;
            end else begin
              result_r <= scaled[15:0];
              clip_r <= 1'b0;
            end
            busy_r <= 1'b0;
            done_r <= 1'b1;
            pending_r <= cont_en;
            if (cont_en) begin
              state_r <= ST_CONV;
              cnt_r <= conv_len - 16'h0001;
            end else begin
              state_r <= ST_IDLE;
            end
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/afe_spi_props.sv
// checker for the serial command port, watching the top-level pins only
`timescale 1ns/1ps
`default_nettype none
module afe_spi_props #(
  parameter [15:0] LAT512_CYC = 16'h7a8f,
  parameter [15:0] LAT256_CYC = 16'h3e80,
  parameter [15:0] LAT128_CYC = 16'h2085,
  parameter [15:0] LAT64_CYC = 16'h1194,
  parameter [15:0] CORR_CYC = 16'h01f4
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic CE,
  input wire logic SCK,
  input wire logic SDI,
  input wire logic SDO,
  input wire logic [1:0] OVERSAMPLING_RATIO,
  input wire logic [18:0] SAMPLE_RAW,
  input wire logic [18:0] OFFSET_VALUE
);
  // ----------------------------------------------------------------------------
  // frame tracking on the raw pins
  // ----------------------------------------------------------------------------
  logic sck_r;
  logic [4:0] rise_r;
  logic [4:0] fall_r;
  logic [3:0] since_r;
  logic [7:0] cmd_r;
  logic [15:0] high_r;
  wire sck_up = SCK & ~sck_r;
  wire sck_dn = ~SCK & sck_r;
  // frame length only meaningful once all eight command bits are in
  wire [4:0] flen = cmd_r[2] ? 5'h18 : 5'h10;
  wire idle = (rise_r == 5'h00) && (fall_r == 5'h00);
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      sck_r <= 1'b0;
      rise_r <= 5'h00;
      fall_r <= 5'h00;
      since_r <= 4'hf;
      cmd_r <= 8'h00;
      high_r <= 16'h0000;
    end else begin
      sck_r <= SCK;
      if (sck_up) begin
        rise_r <= rise_r + 5'h01;
        since_r <= 4'h0;
      end else if (since_r != 4'hf) begin
        since_r <= since_r + 4'h1;
      end
      if (sck_dn) begin
        if (fall_r < 5'h08) begin
          cmd_r <= {cmd_r[6:0], SDI};
        end
        if (fall_r >= 5'h08 && fall_r + 5'h01 == flen) begin
          rise_r <= 5'h00;
          fall_r <= 5'h00;
        end else begin
          fall_r <= fall_r + 5'h01;
        end
      end
      high_r <= (idle && SDO) ? high_r + 16'h0001 : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  sequence s_low_run;
    (!SDO) [*8];
  endsequence
  sequence s_high_run;
    SDO [*8];
  endsequence
  wire settled = since_r == 4'h7;
  a_rst_idle_low: assert property ($fell(SRST) |-> s_low_run)
    else $error("data-out not low after reset");
  a_out_on_rise: assert property ((rise_r != 5'h00) && $changed(SDO) |-> since_r <= 4'h6)
    else $error("data-out moved away from a clock rise");
  a_status_zero: assert property (rise_r >= 5'h01 && rise_r <= 5'h06 && settled |-> !SDO)
    else $error("status upper bits not zero");
  a_ctrl_msb_zero: assert property (rise_r == 5'h09 && settled && cmd_r[7:3] == 5'h01 |-> !SDO)
    else $error("control read bit 7 not zero");
  a_unmapped_zero: assert property (rise_r >= 5'h09 && settled && cmd_r[3] &&
      (cmd_r[7:4] > 4'h2 || (cmd_r[7:4] == 4'h2 && rise_r >= 5'h11)) |-> !SDO)
    else $error("unmapped read not zero");
  a_busy_bound: assert property (high_r <= LAT512_CYC + 16'h0040)
    else $error("busy held longer than the slowest conversion");
  a_ready_hold: assert property (idle && $fell(SDO) |=> s_low_run)
    else $error("ready indication too short");
  a_busy_hold: assert property (idle && $rose(SDO) |=> s_high_run)
    else $error("busy indication too short");
endmodule
bind afe_spi_port afe_spi_props #(.LAT512_CYC(LAT512_CYC), .LAT256_CYC(LAT256_CYC),
  .LAT128_CYC(LAT128_CYC), .LAT64_CYC(LAT64_CYC), .CORR_CYC(CORR_CYC)) i_props (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .SCK(SCK), .SDI(SDI), .SDO(SDO),
  .OVERSAMPLING_RATIO(OVERSAMPLING_RATIO), .SAMPLE_RAW(SAMPLE_RAW),
  .OFFSET_VALUE(OFFSET_VALUE));
`default_nettype wire

// ### tb/afe_spi_master.sv
// microcontroller model driving the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module afe_spi_master #(
  parameter int HALF = 8
) (
  input wire logic clk,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  // clock rests still between frames; no select line exists
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
  end
  // one frame of n bits, msb first both ways; gap keeps frames apart
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      #1;
      sdi = tx[i];
      sck = 1'b1;
      repeat (HALF) @(posedge clk);
      #1;
      rx[i] = sdo;
      sck = 1'b0;
      repeat (HALF) @(posedge clk);
    end
    repeat (2 * HALF) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int L64 = 800;
  localparam int CORR = 100;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] oversampling_ratio = 2'h3;
  logic [18:0] raw = 19'h00800;
  logic [18:0] offs = 19'h00100;
  logic [23:0] rx;
  int n_mismatch = 0;
  int compares = 0;
  int c;
  wire sck;
  wire sdi;
  wire sdo;
  always #20 clk_sys = ~clk_sys;
  afe_spi_port #(.LAT512_CYC(16'h0640), .LAT256_CYC(16'h0514), .LAT128_CYC(16'h03e8),
    .LAT64_CYC(16'h0320), .CORR_CYC(16'h0064)) i_dut (
    .CLK_SYS(clk_sys), .SRST(srst), .CE(ce), .SCK(sck), .SDI(sdi), .SDO(sdo),
    .OVERSAMPLING_RATIO(oversampling_ratio), .SAMPLE_RAW(raw), .OFFSET_VALUE(offs));
  afe_spi_master i_mst (.clk(clk_sys), .sck(sck), .sdi(sdi), .sdo(sdo));

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // whole latency per ratio code, matching the shortened counts given to i_dut
  function automatic int lat_of(input int k);
    case (k)
      0: return 1600;
      1: return 1300;
      2: return 1000;
      default: return 800;
    endcase
  endfunction
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask
  task automatic wait_sdo(input logic lvl, output int cyc);
    cyc = 0;
    while (sdo !== lvl) begin
      @(posedge clk_sys);
      #1;
      cyc++;
      if (cyc > 4000) begin
        n_mismatch++;
        complete_run();
      end
    end
  endtask
  // command bits 1:0 always sent as zero
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_mst.xfer(16, {8'h00, a, 4'h0, d}, rx);
  endtask
  task automatic rd1(input logic [3:0] a);
    i_mst.xfer(16, {8'h00, a, 4'h8, 8'h00}, rx);
  endtask
  task automatic rd2(input logic [3:0] a);
    i_mst.xfer(24, {a, 4'hc, 16'h0000}, rx);
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_registers;
    check(sdo, 1'b0);
    rd1(4'h0);
    check(rx[15:0], 16'h0000);
    wr(4'h3, 8'hff);
    rd1(4'h3);
    check(rx[15:0], 16'h0000);
    wr(4'h0, 8'h40);
    rd1(4'h0);
    check(rx[15:0], 16'h0040);
    wr(4'h0, 8'h00);
  endtask
  task automatic t_single;
    for (int k = 0; k < 4; k++) begin
      oversampling_ratio = k[1:0];
      wr(4'h0, 8'h02);
      check(sdo, 1'b1);
      wait_sdo(1'b0, c);
      in_range(c, lat_of(k) - 40, lat_of(k) + 5);
      rd2(4'h1);
      check(rx, 24'h0000e0);
    end
  endtask
  task automatic t_swap_clip;
    raw = 19'h00400;
    offs = 19'h00200;
    wr(4'h0, 8'h42);
    wait_sdo(1'b0, c);
    rd2(4'h1);
    check(rx, 24'h000080);
    raw = 19'h3ffff;
    offs = 19'h40000;
    wr(4'h0, 8'h02);
    wait_sdo(1'b0, c);
    rd1(4'h1);
    check(rx[15:0], 16'h017f);
    rd1(4'h2);
    check(rx[15:0], 16'h01ff);
    rd1(4'h0);
    check(rx[15:0], 16'h0112);
    raw = 19'h40000;
    offs = 19'h3ffff;
    wr(4'h0, 8'h02);
    wait_sdo(1'b0, c);
    rd2(4'h1);
    check(rx, 24'h018000);
    raw = 19'h00800;
    offs = 19'h00100;
    wr(4'h0, 8'h02);
    wait_sdo(1'b0, c);
    rd1(4'h0);
    check(rx[15:0], 16'h0002);
  endtask
  task automatic t_continuous;
    oversampling_ratio = 2'h3;
    wr(4'h0, 8'h03);
    wait_sdo(1'b0, c);
    rd2(4'h1);
    check(rx, 24'h0000e0);
    check(sdo, 1'b1);
    wait_sdo(1'b0, c);
    wait_sdo(1'b1, c);
    in_range(c, L64 - 2 * CORR - 10, L64 - CORR + 10);
    wait_sdo(1'b0, c);
    in_range(c, CORR - 4, CORR + 4);
    wr(4'h0, 8'h00);
  endtask
  task automatic t_inband_reset;
    wr(4'h0, 8'h40);
    i_mst.xfer(24, 24'h7fffff, rx);
    rd1(4'h0);
    check(rx[15:0], 16'h0000);
    check(sdo, 1'b0);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    t_registers();
    t_single();
    t_swap_clip();
    t_continuous();
    t_inband_reset();
    complete_run();
  end
endmodule
`default_nettype wire
